// ### hsto_pkg.sv
// Package of constants and types for the high-speed timer compare output block
package hsto_pkg;

	// Register bus geometry
	localparam int unsigned HSTO_ADDR_W = 8;
	localparam int unsigned HSTO_DATA_W = 32;
	localparam int unsigned HSTO_CNT_W  = 10;

	// Register byte offsets
	localparam logic [7:0] HSTO_OFF_WAVE_CTRL_A = 8'h00;
	localparam logic [7:0] HSTO_OFF_WAVE_GEN    = 8'h04;
	localparam logic [7:0] HSTO_OFF_HIGH_TEMP   = 8'h08;
	localparam logic [7:0] HSTO_OFF_CMP_A_LOW   = 8'h0C;
	localparam logic [7:0] HSTO_OFF_CMP_B_LOW   = 8'h10;
	localparam logic [7:0] HSTO_OFF_STATUS      = 8'h14;

	// Field positions in waveform_ctrl_a
	localparam int unsigned HSTO_MODE_A_LSB  = 6;
	localparam int unsigned HSTO_MODE_B_LSB  = 4;
	localparam int unsigned HSTO_FORCE_A_BIT = 3;
	localparam int unsigned HSTO_FORCE_B_BIT = 2;
	localparam int unsigned HSTO_PWM_A_BIT   = 1;
	localparam int unsigned HSTO_PWM_B_BIT   = 0;

	// Field positions in the wave generation register
	localparam int unsigned HSTO_WGEN_BIT0 = 0;
	localparam int unsigned HSTO_WGEN_BIT1 = 1;

	// Field positions in the status register
	localparam int unsigned HSTO_ST_WAVE_A  = 0;
	localparam int unsigned HSTO_ST_WAVE_B  = 1;
	localparam int unsigned HSTO_ST_A_OVR   = 2;
	localparam int unsigned HSTO_ST_A_N_OVR = 3;
	localparam int unsigned HSTO_ST_B_OVR   = 4;
	localparam int unsigned HSTO_ST_B_N_OVR = 5;

	// Reset values
	localparam logic [7:0]            HSTO_WAVE_CTRL_RST = 8'h00;
	localparam logic [1:0]            HSTO_WGEN_RST      = 2'h0;
	localparam logic [1:0]            HSTO_TEMP_RST      = 2'h0;
	localparam logic [HSTO_CNT_W-1:0] HSTO_CMP_RST       = 10'h000;
	localparam logic [HSTO_CNT_W-1:0] HSTO_CNT_BOTTOM    = 10'h000;

	// Compare output mode codes
	localparam logic [1:0] HSTO_CODE_PORT   = 2'h0;
	localparam logic [1:0] HSTO_CODE_TOGGLE = 2'h1;
	localparam logic [1:0] HSTO_CODE_CLEAR  = 2'h2;
	localparam logic [1:0] HSTO_CODE_SET    = 2'h3;

	// How a channel's waveform reacts to counter events
	typedef enum logic [1:0] {
		HSTO_NON_PWM,
		HSTO_SINGLE_SLOPE,
		HSTO_DUAL_SLOPE
	} hsto_slope_t;

endpackage

// ### hsto_chan_if.sv
// Interface between the control logic and one channel waveform unit
interface hsto_chan_if;
	import hsto_pkg::*;

	logic [1:0]  mode;
	hsto_slope_t slope;
	logic        match;
	logic        bottom;
	logic        count_down;
	logic        force_cmp;
	logic        wave;

	modport ctrl (
		output mode,
		output slope,
		output match,
		output bottom,
		output count_down,
		output force_cmp,
		input  wave
	);

	modport unit (
		input  mode,
		input  slope,
		input  match,
		input  bottom,
		input  count_down,
		input  force_cmp,
		output wave
	);

endinterface

// ### hsto_wave_unit.sv
// Waveform output register of one compare channel
module hsto_wave_unit
	import hsto_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Channel controls and events
	hsto_chan_if.unit ch
);

	logic wave_r;
	logic wave_nxt;

	// Next waveform value from the mode code and the counter events
	always_comb begin
		wave_nxt = wave_r;
		unique case (ch.slope)
			HSTO_NON_PWM: begin
				if (ch.match || ch.force_cmp) begin
					if (ch.mode == HSTO_CODE_TOGGLE) begin
						wave_nxt = ~wave_r;
					end else if (ch.mode == HSTO_CODE_CLEAR) begin
						wave_nxt = 1'b0;
					end else if (ch.mode == HSTO_CODE_SET) begin
						wave_nxt = 1'b1;
					end
				end
			end
			HSTO_SINGLE_SLOPE: begin
				// Match is applied last so a match at bottom wins
				if (ch.mode != HSTO_CODE_PORT) begin
					if (ch.bottom) begin
						wave_nxt = (ch.mode != HSTO_CODE_SET);
					end
					if (ch.match) begin
						wave_nxt = (ch.mode == HSTO_CODE_SET);
					end
				end
			end
			HSTO_DUAL_SLOPE: begin
				if (ch.mode != HSTO_CODE_PORT && ch.match) begin
					wave_nxt = (ch.mode == HSTO_CODE_SET) ^ ch.count_down;
				end
			end
			default: begin
				wave_nxt = wave_r;
			end
		endcase
	end

	// Waveform register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wave_r <= 1'b0;
		end else begin
			wave_r <= wave_nxt;
		end
	end

	assign ch.wave = wave_r;

endmodule // hsto_wave_unit

// ### hsto_compare_out.sv
// Compare output mode logic for channels A and B with an APB register slave
//
// Summary of operation
// - Nonzero mode code hands the channel's true pin to the timer; in six-output mode channel A's code decides for both channels.
// - Complement pin connects in PWM modes with code 01, and in six-output mode with any nonzero code.
// - Channel A mode meaning depends on its PWM enable and both wave bits.
// - Channel B mode meaning depends on its PWM enable and wave bit 0.
// - Non-PWM: 00 port, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 01/10 clear on match, set at bottom; 11 inverse.
// - Dual slope: 01/10 clear on up match, set on down; 11 reverse.
// - Single-slope six-output: channel A waveform drives all paired pins.
// - Dual-slope six-output: channel A up/down waveform drives all pins.
// - Channel B has normal, fast and dual-slope modes like channel A.
// - Force bit in non-PWM applies the match action; reads as zero.
// - PWM enable selects PWM operation on the channel's own compare.
//
// Decided for this implementation: the address map and the APB register port.
module hsto_compare_out
	import hsto_pkg::*;
(
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [HSTO_ADDR_W-1:0] paddr,
	input  wire logic [HSTO_DATA_W-1:0] pwdata,
	output logic      [HSTO_DATA_W-1:0] prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Counter state from the timer core
	input  wire logic [HSTO_CNT_W-1:0]  hs_counter_value,
	input  wire logic                   cnt_tick,
	input  wire logic                   cnt_down,
	// Channel A pins
	output logic                        chan_a_pin,
	output logic                        chan_a_pin_ovr,
	output logic                        chan_a_pin_n,
	output logic                        chan_a_pin_n_ovr,
	// Channel B pins
	output logic                        chan_b_pin,
	output logic                        chan_b_pin_ovr,
	output logic                        chan_b_pin_n,
	output logic                        chan_b_pin_n_ovr
);

	// Address match, used by both the read mux and the write strobes
	function automatic logic hsto_hit(input logic [HSTO_ADDR_W-1:0] addr,
		input logic [7:0] off);
		hsto_hit = (addr == off);
	endfunction

	// Slope selection for a channel from its PWM enable and the dual-slope bit
	function automatic hsto_slope_t hsto_slope_of(input logic pwm_en, input logic dual);
		if (!pwm_en) begin
			hsto_slope_of = HSTO_NON_PWM;
		end else if (dual) begin
			hsto_slope_of = HSTO_DUAL_SLOPE;
		end else begin
			hsto_slope_of = HSTO_SINGLE_SLOPE;
		end
	endfunction

	function automatic logic hsto_owned(input logic [1:0] code);
		hsto_owned = (code != HSTO_CODE_PORT);
	endfunction

	function automatic logic hsto_comp_owned(input logic pwm_en, input logic [1:0] code);
		hsto_comp_owned = pwm_en && (code == HSTO_CODE_TOGGLE);
	endfunction

	// Control register state
	logic [1:0]            chan_a_out_mode_r;
	logic [1:0]            chan_b_out_mode_r;
	logic                  chan_a_pwm_enable_r;
	logic                  chan_b_pwm_enable_r;
	logic                  wave_gen_bit0_r;
	logic                  wave_gen_bit1_r;
	logic [1:0]            shared_high_byte_temp_r;
	logic [HSTO_CNT_W-1:0] chan_a_compare_value_r;
	logic [HSTO_CNT_W-1:0] chan_b_compare_value_r;
	logic                  force_a_r;
	logic                  force_b_r;

	// Bus state
	logic                   pready_r;
	logic                   pslverr_r;
	logic [HSTO_DATA_W-1:0] prdata_r;
	logic [HSTO_DATA_W-1:0] rdata_nxt;
	logic                   mapped;
	logic                   access_done;
	logic                   wr_en;
	logic                   rd_en;

	// Pin state
	logic chan_a_pin_r;
	logic chan_a_pin_ovr_r;
	logic chan_a_pin_n_r;
	logic chan_a_pin_n_ovr_r;
	logic chan_b_pin_r;
	logic chan_b_pin_ovr_r;
	logic chan_b_pin_n_r;
	logic chan_b_pin_n_ovr_r;

	// Derived mode decode
	logic six_output_pwm;
	logic chan_a_waveform;
	logic chan_b_waveform;
	logic cnt_at_bottom;

	// Transfer completes on the access cycle in which pready is high
	assign access_done = psel && penable && pready_r;
	assign wr_en       = access_done && pwrite && !pslverr_r;
	assign rd_en       = access_done && !pwrite && !pslverr_r;

	// Status is read only, so a write to it is refused like an unmapped one
	assign mapped = hsto_hit(paddr, HSTO_OFF_WAVE_CTRL_A)
		|| hsto_hit(paddr, HSTO_OFF_WAVE_GEN)
		|| hsto_hit(paddr, HSTO_OFF_HIGH_TEMP)
		|| hsto_hit(paddr, HSTO_OFF_CMP_A_LOW)
		|| hsto_hit(paddr, HSTO_OFF_CMP_B_LOW)
		|| (hsto_hit(paddr, HSTO_OFF_STATUS) && !pwrite);

	// Read data mux; force bits are never stored and read as zero
	always_comb begin
		rdata_nxt = '0;
		if (hsto_hit(paddr, HSTO_OFF_WAVE_CTRL_A)) begin
			rdata_nxt[HSTO_MODE_A_LSB +: 2] = chan_a_out_mode_r;
			rdata_nxt[HSTO_MODE_B_LSB +: 2] = chan_b_out_mode_r;
			rdata_nxt[HSTO_PWM_A_BIT]       = chan_a_pwm_enable_r;
			rdata_nxt[HSTO_PWM_B_BIT]       = chan_b_pwm_enable_r;
		end else if (hsto_hit(paddr, HSTO_OFF_WAVE_GEN)) begin
			rdata_nxt[HSTO_WGEN_BIT0] = wave_gen_bit0_r;
			rdata_nxt[HSTO_WGEN_BIT1] = wave_gen_bit1_r;
		end else if (hsto_hit(paddr, HSTO_OFF_HIGH_TEMP)) begin
			rdata_nxt[1:0] = shared_high_byte_temp_r;
		end else if (hsto_hit(paddr, HSTO_OFF_CMP_A_LOW)) begin
			rdata_nxt[7:0] = chan_a_compare_value_r[7:0];
		end else if (hsto_hit(paddr, HSTO_OFF_CMP_B_LOW)) begin
			rdata_nxt[7:0] = chan_b_compare_value_r[7:0];
		end else if (hsto_hit(paddr, HSTO_OFF_STATUS)) begin
			rdata_nxt[HSTO_ST_WAVE_A]  = chan_a_waveform;
			rdata_nxt[HSTO_ST_WAVE_B]  = chan_b_waveform;
			rdata_nxt[HSTO_ST_A_OVR]   = chan_a_pin_ovr_r;
			rdata_nxt[HSTO_ST_A_N_OVR] = chan_a_pin_n_ovr_r;
			rdata_nxt[HSTO_ST_B_OVR]   = chan_b_pin_ovr_r;
			rdata_nxt[HSTO_ST_B_N_OVR] = chan_b_pin_n_ovr_r;
		end
	end

	// APB answer: one wait-free access cycle, data captured in setup
	// Capturing in setup keeps the read mux off the access path; the cost is
	// that a register changing at the setup edge reads its older value
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end else begin
			pready_r <= psel && !penable;
			if (psel && !penable) begin
				pslverr_r <= !mapped;
				prdata_r  <= mapped ? rdata_nxt : '0;
			end else begin
				pslverr_r <= 1'b0;
				prdata_r  <= '0;
			end
		end
	end

	// Control register: mode codes and PWM enables
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			chan_a_out_mode_r   <= HSTO_WAVE_CTRL_RST[HSTO_MODE_A_LSB +: 2];
			chan_b_out_mode_r   <= HSTO_WAVE_CTRL_RST[HSTO_MODE_B_LSB +: 2];
			chan_a_pwm_enable_r <= HSTO_WAVE_CTRL_RST[HSTO_PWM_A_BIT];
			chan_b_pwm_enable_r <= HSTO_WAVE_CTRL_RST[HSTO_PWM_B_BIT];
		end else if (wr_en && hsto_hit(paddr, HSTO_OFF_WAVE_CTRL_A)) begin
			chan_a_out_mode_r   <= pwdata[HSTO_MODE_A_LSB +: 2];
			chan_b_out_mode_r   <= pwdata[HSTO_MODE_B_LSB +: 2];
			chan_a_pwm_enable_r <= pwdata[HSTO_PWM_A_BIT];
			chan_b_pwm_enable_r <= pwdata[HSTO_PWM_B_BIT];
		end
	end

	// Force strobes last one cycle, aligned with the newly written modes
	// A force written together with a PWM enable is dropped, not deferred
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			force_a_r <= 1'b0;
			force_b_r <= 1'b0;
		end else begin
			force_a_r <= wr_en && hsto_hit(paddr, HSTO_OFF_WAVE_CTRL_A)
				&& pwdata[HSTO_FORCE_A_BIT] && !pwdata[HSTO_PWM_A_BIT];
			force_b_r <= wr_en && hsto_hit(paddr, HSTO_OFF_WAVE_CTRL_A)
				&& pwdata[HSTO_FORCE_B_BIT] && !pwdata[HSTO_PWM_B_BIT];
		end
	end

	// Wave generation register
	// Channel B never reads bit 1; only the six-output select does
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wave_gen_bit0_r <= HSTO_WGEN_RST[HSTO_WGEN_BIT0];
			wave_gen_bit1_r <= HSTO_WGEN_RST[HSTO_WGEN_BIT1];
		end else if (wr_en && hsto_hit(paddr, HSTO_OFF_WAVE_GEN)) begin
			wave_gen_bit0_r <= pwdata[HSTO_WGEN_BIT0];
			wave_gen_bit1_r <= pwdata[HSTO_WGEN_BIT1];
		end
	end

	// Shared high byte: written directly, reloaded by a low-byte read.
	// It is not cleared by a low-byte write, so one high write serves many.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			shared_high_byte_temp_r <= HSTO_TEMP_RST;
		end else if (wr_en && hsto_hit(paddr, HSTO_OFF_HIGH_TEMP)) begin
			shared_high_byte_temp_r <= pwdata[1:0];
		end else if (rd_en && hsto_hit(paddr, HSTO_OFF_CMP_A_LOW)) begin
			shared_high_byte_temp_r <= chan_a_compare_value_r[HSTO_CNT_W-1:8];
		end else if (rd_en && hsto_hit(paddr, HSTO_OFF_CMP_B_LOW)) begin
			shared_high_byte_temp_r <= chan_b_compare_value_r[HSTO_CNT_W-1:8];
		end
	end

	// Compare values load all ten bits at the low-byte write
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			chan_a_compare_value_r <= HSTO_CMP_RST;
			chan_b_compare_value_r <= HSTO_CMP_RST;
		end else begin
			if (wr_en && hsto_hit(paddr, HSTO_OFF_CMP_A_LOW)) begin
				chan_a_compare_value_r <= {shared_high_byte_temp_r, pwdata[7:0]};
			end
			if (wr_en && hsto_hit(paddr, HSTO_OFF_CMP_B_LOW)) begin
				chan_b_compare_value_r <= {shared_high_byte_temp_r, pwdata[7:0]};
			end
		end
	end

	// Counter events are only valid on the core's tick
	// The core runs on this clock, so its outputs need no synchroniser
	assign cnt_at_bottom = cnt_tick && (hs_counter_value == HSTO_CNT_BOTTOM);

	// Channel B's own mode and PWM bit are ignored while this is set
	// six-output select
	assign six_output_pwm = chan_a_pwm_enable_r && wave_gen_bit1_r;

	// One interface and one waveform unit per channel
	hsto_chan_if ch_if [2] ();

	assign ch_if[0].mode       = chan_a_out_mode_r;
	assign ch_if[0].slope      = hsto_slope_of(chan_a_pwm_enable_r, wave_gen_bit0_r);
	assign ch_if[0].match      = cnt_tick && (hs_counter_value == chan_a_compare_value_r);
	assign ch_if[0].force_cmp  = force_a_r;

	assign ch_if[1].mode       = chan_b_out_mode_r;
	assign ch_if[1].slope      = hsto_slope_of(chan_b_pwm_enable_r, wave_gen_bit0_r);
	assign ch_if[1].match      = cnt_tick && (hs_counter_value == chan_b_compare_value_r);
	assign ch_if[1].force_cmp  = force_b_r;

	// Shared counter events and the waveform units
	for (genvar g = 0; g < 2; g++) begin : g_chan
		assign ch_if[g].bottom     = cnt_at_bottom;
		assign ch_if[g].count_down = cnt_down;
		hsto_wave_unit u_wave (
			.clock   (clock),
			.sys_rst (sys_rst),
			.ch      (ch_if[g])
		);
	end

	assign chan_a_waveform = ch_if[0].wave;
	assign chan_b_waveform = ch_if[1].wave;

	// Channel A pin takeover and levels
	// Registered pins cost a cycle of delay but keep decode glitches off the load
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			chan_a_pin_r       <= 1'b0;
			chan_a_pin_ovr_r   <= 1'b0;
			chan_a_pin_n_r     <= 1'b1;
			chan_a_pin_n_ovr_r <= 1'b0;
		end else begin
			chan_a_pin_r       <= chan_a_waveform;
			chan_a_pin_n_r     <= !chan_a_waveform;
			chan_a_pin_ovr_r   <= hsto_owned(chan_a_out_mode_r);
			if (six_output_pwm) begin
				chan_a_pin_n_ovr_r <= hsto_owned(chan_a_out_mode_r);
			end else begin
				chan_a_pin_n_ovr_r <= hsto_comp_owned(chan_a_pwm_enable_r,
					chan_a_out_mode_r);
			end
		end
	end

	// Channel B pins; in six-output mode they carry channel A's waveform
	// Levels keep moving while unowned, so a takeover shows the live waveform
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			chan_b_pin_r       <= 1'b0;
			chan_b_pin_ovr_r   <= 1'b0;
			chan_b_pin_n_r     <= 1'b1;
			chan_b_pin_n_ovr_r <= 1'b0;
		end else if (six_output_pwm) begin
			chan_b_pin_r       <= chan_a_waveform;
			chan_b_pin_n_r     <= !chan_a_waveform;
			chan_b_pin_ovr_r   <= hsto_owned(chan_a_out_mode_r);
			chan_b_pin_n_ovr_r <= hsto_owned(chan_a_out_mode_r);
		end else begin
			chan_b_pin_r       <= chan_b_waveform;
			chan_b_pin_n_r     <= !chan_b_waveform;
			chan_b_pin_ovr_r   <= hsto_owned(chan_b_out_mode_r);
			chan_b_pin_n_ovr_r <= hsto_comp_owned(chan_b_pwm_enable_r,
				chan_b_out_mode_r);
		end
	end

	// Overrides only steer the port mux; driver enables stay with the port.
	// drivers left to software
	assign chan_a_pin_ovr   = chan_a_pin_ovr_r;
	assign chan_a_pin_n_ovr = chan_a_pin_n_ovr_r;
	assign chan_b_pin_ovr   = chan_b_pin_ovr_r;
	assign chan_b_pin_n_ovr = chan_b_pin_n_ovr_r;
	assign chan_a_pin       = chan_a_pin_r;
	assign chan_a_pin_n     = chan_a_pin_n_r;
	assign chan_b_pin       = chan_b_pin_r;
	assign chan_b_pin_n     = chan_b_pin_n_r;

	// Bus outputs
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

endmodule // hsto_compare_out

// ### hsto_load.sv
// Load model that sees the four output lines of the compare block
module hsto_load (
	// Block side
	input  wire logic [3:0] pin,
	input  wire logic [3:0] ovr,
	// Port logic and driver enables
	input  wire logic [3:0] port_lvl,
	input  wire logic [3:0] drv_en,
	// Level at the load
	output logic      [3:0] lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// owner, driver enable
	// A line whose driver is off is pulled low, so stale levels never show
	assign lvl = drv_en & ((ovr & pin) | (~ovr & port_lvl));
endmodule // hsto_load

// ### hsto_compare_out_chk.sv
// Port checker for the compare output block
module hsto_compare_out_chk
	import hsto_pkg::*;
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Counter
	input wire logic [9:0]  hs_counter_value,
	input wire logic        cnt_tick,
	input wire logic        cnt_down,
	// Pins
	input wire logic        chan_a_pin,
	input wire logic        chan_a_pin_ovr,
	input wire logic        chan_a_pin_n,
	input wire logic        chan_a_pin_n_ovr,
	input wire logic        chan_b_pin,
	input wire logic        chan_b_pin_ovr,
	input wire logic        chan_b_pin_n,
	input wire logic        chan_b_pin_n_ovr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Bus phases seen as plain signals so $past gets a signal
	wire setup  = psel && !penable;
	wire wr_acc = psel && penable && pready && pwrite;

	ready_after_setup_a: assert property (setup |=> pready)
		else $error("pready missing after setup");
	ready_in_access_a: assert property (pready |-> psel && penable && $past(setup))
		else $error("pready outside access");
	bad_addr_err_a: assert property (setup && paddr > 8'h14 |=> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	status_ro_err_a: assert property (setup && pwrite && paddr == 8'h14 |=> pslverr)
		else $error("status write not refused");
	comp_a_owned_a: assert property (chan_a_pin_n_ovr |-> chan_a_pin_ovr)
		else $error("complement A without true A");
	comp_b_owned_a: assert property (chan_b_pin_n_ovr |-> chan_b_pin_ovr)
		else $error("complement B without true B");
	pair_a_inverse_a: assert property (chan_a_pin_n != chan_a_pin)
		else $error("A pin pair not inverse");
	pair_b_inverse_a: assert property (chan_b_pin_n != chan_b_pin)
		else $error("B pin pair not inverse");
	pin_a_cause_a: assert property ($changed(chan_a_pin) |->
		$past(cnt_tick, 2) || $past(wr_acc, 3)) else $error("A pin moved without cause");
	ovr_a_late_a: assert property ($changed(chan_a_pin_ovr) |-> $past(wr_acc, 2))
		else $error("A takeover not two cycles after write");

	cover property (setup && pwrite ##1 pready);
	cover property ($rose(chan_a_pin_n_ovr));
	cover property ($rose(chan_b_pin_ovr) && chan_a_pin_ovr);
endmodule // hsto_compare_out_chk

bind hsto_compare_out hsto_compare_out_chk i_hsto_compare_out_chk (.clock(clock),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.hs_counter_value(hs_counter_value), .cnt_tick(cnt_tick), .cnt_down(cnt_down),
	.chan_a_pin(chan_a_pin), .chan_a_pin_ovr(chan_a_pin_ovr), .chan_a_pin_n(chan_a_pin_n),
	.chan_a_pin_n_ovr(chan_a_pin_n_ovr), .chan_b_pin(chan_b_pin),
	.chan_b_pin_ovr(chan_b_pin_ovr), .chan_b_pin_n(chan_b_pin_n),
	.chan_b_pin_n_ovr(chan_b_pin_n_ovr));

// ### tb_hsto_compare_out.sv
// Testbench for the compare output block
module tb_hsto_compare_out
	import hsto_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prdata;
	wire         pready, pslverr;
	logic [9:0]  cnt_val = 10'h000;
	logic        cnt_tick = 1'b0, cnt_down = 1'b0;
	wire  [3:0]  pin, ovr, lvl;
	logic [3:0]  drv = 4'hF;
	int          mismatches = 0, n_compared = 0;

	hsto_compare_out i_hsto_compare_out (.clock(clock), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hs_counter_value(cnt_val), .cnt_tick(cnt_tick),
		.cnt_down(cnt_down), .chan_a_pin(pin[0]), .chan_a_pin_ovr(ovr[0]),
		.chan_a_pin_n(pin[1]), .chan_a_pin_n_ovr(ovr[1]), .chan_b_pin(pin[2]),
		.chan_b_pin_ovr(ovr[2]), .chan_b_pin_n(pin[3]), .chan_b_pin_n_ovr(ovr[3]));
	// Port logic drives low so only timer-owned lines can read high
	hsto_load i_hsto_load (.pin(pin), .ovr(ovr), .port_lvl(4'h0), .drv_en(drv), .lvl(lvl));

	// 125 MHz clock
	always #4 clock = ~clock;

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	// One APB transfer, request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk("prdata", q, x);
	endtask
	// Counter event; pins settle one edge after the waveform
	task automatic ev(input logic [9:0] v, input logic d, input logic [3:0] eo,
		input logic [3:0] el);
		@(posedge clock);
		cnt_val <= v;
		cnt_down <= d;
		cnt_tick <= 1'b1;
		@(posedge clock);
		cnt_tick <= 1'b0;
		@(posedge clock);
		#1;
		chk("ovr", 32'(ovr), 32'(eo));
		chk("lvl", 32'(lvl), 32'(el));
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		rd(8'h00, 32'h0);
		rd(8'h14, 32'h0);
		apb(1'b0, 8'h18, 32'h0, q, e);
		chk("pslverr", 32'(e), 32'h1);
		apb(1'b1, 8'h14, 32'hFF, q, e);
		chk("pslverr", 32'(e), 32'h1);
	endtask
	// One high write serves both low writes
	task automatic t_shared();
		wr(8'h08, 32'h1);
		wr(8'h0C, 32'h23);
		wr(8'h10, 32'h23);
		wr(8'h00, 32'h50);
		ev(10'h023, 1'b0, 4'h5, 4'h0);
		ev(10'h123, 1'b0, 4'h5, 4'h5);
		rd(8'h14, 32'h17);
		wr(8'h08, 32'h0);
		rd(8'h0C, 32'h23);
		rd(8'h08, 32'h1);
	endtask
	task automatic t_codes();
		for (int c = 1; c < 4; c++) begin
			wr(8'h00, 32'(c << 6));
			ev(10'h123, 1'b0, 4'h1, 4'(c == 3));
		end
		wr(8'h00, 32'h0);
		ev(10'h123, 1'b0, 4'h0, 4'h0);
	endtask
	task automatic t_force();
		wr(8'h00, 32'h48);
		repeat (2) @(posedge clock);
		#1;
		chk("lvl", 32'(lvl), 32'h0);
		rd(8'h00, 32'h40);
		wr(8'h00, 32'h4A);
		repeat (2) @(posedge clock);
		#1;
		chk("lvl", 32'(lvl), 32'h2);
	endtask
	task automatic t_fast();
		wr(8'h00, 32'h42);
		ev(10'h000, 1'b0, 4'h3, 4'h1);
		ev(10'h123, 1'b0, 4'h3, 4'h2);
		wr(8'h00, 32'h82);
		ev(10'h000, 1'b0, 4'h1, 4'h1);
		wr(8'h00, 32'hC2);
		ev(10'h000, 1'b0, 4'h1, 4'h0);
		ev(10'h123, 1'b0, 4'h1, 4'h1);
	endtask
	task automatic t_dual();
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h42);
		ev(10'h123, 1'b0, 4'h3, 4'h2);
		ev(10'h123, 1'b1, 4'h3, 4'h1);
		wr(8'h00, 32'hC2);
		ev(10'h123, 1'b1, 4'h1, 4'h0);
		ev(10'h123, 1'b0, 4'h1, 4'h1);
		ev(10'h000, 1'b0, 4'h1, 4'h1);
	endtask
	task automatic t_six();
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h82);
		ev(10'h123, 1'b0, 4'hF, 4'hA);
		ev(10'h000, 1'b0, 4'hF, 4'h5);
		wr(8'h04, 32'h3);
		ev(10'h123, 1'b0, 4'hF, 4'hA);
	endtask
	// Upper wave bit set but channel B must ignore it
	task automatic t_chan_b();
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h11);
		ev(10'h123, 1'b0, 4'hC, 4'h8);
		ev(10'h000, 1'b0, 4'hC, 4'h4);
		wr(8'h04, 32'h3);
		ev(10'h123, 1'b0, 4'hC, 4'h8);
		ev(10'h000, 1'b0, 4'hC, 4'h8);
		ev(10'h123, 1'b1, 4'hC, 4'h4);
	endtask
	// Owned line with its driver off stays low at the load
	task automatic t_drive();
		@(posedge clock);
		drv <= 4'h3;
		@(posedge clock);
		#1;
		chk("lvl", 32'(lvl), 32'h0);
		@(posedge clock);
		drv <= 4'hF;
		@(posedge clock);
		#1;
		chk("lvl", 32'(lvl), 32'h4);
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence, each scenario starts from the previous waveform state
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_shared();
		t_codes();
		t_force();
		t_fast();
		t_dual();
		t_six();
		t_chan_b();
		t_drive();
		wrap_up();
	end
	// Watchdog, far beyond the roughly 190 cycles the tests need
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
endmodule // tb_hsto_compare_out
